// File: core/dsm_monitor.sv
/*
 * Dual channel safety input monitor: decodes two single-channel safety inputs,
 * checks synchronization and signal interlock, and drives the safety output.
 * Assumes all inputs are synchronous to clock and a plain register port master.
 */
// The register offsets and the address-and-strobe port were left to the implementer.

`timescale 1ns/1ps

module dsm_monitor
	import dsm_pkg::*;
#(
	// Window lengths in cycles; each application function may pick its own set.
	parameter int unsigned SYNC_CYC_P = dsm_pkg::SYNC_CYC,
	parameter int unsigned ACT_CYC_P = dsm_pkg::ACT_CYC,
	parameter int unsigned RESP_CYC_P = dsm_pkg::RESP_CYC,
	parameter int unsigned LOCK_CYC_P = dsm_pkg::LOCK_CYC,
	parameter int unsigned CLEAR_CYC_P = dsm_pkg::CLEAR_CYC
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic normally_open_channel,
	input wire logic normally_closed_channel,
	input wire logic start_in,
	input wire logic [dsm_pkg::AW-1:0] reg_addr,
	input wire logic [dsm_pkg::DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [dsm_pkg::DW-1:0] reg_rdata,
	output logic safety_out,
	output logic irq
);
	import dsm_pkg::*;

	// ****************************************************************
	// State.
	// ****************************************************************
	typedef struct packed {
		dsm_state_t state;
		logic [DW-1:0] ctrl;
		logic [DW-1:0] rdata;
		logic out;
		logic sync_fail;
		logic lock;
		logic from_both;
		logic dropped;
	} dsm_mon_t;

	dsm_mon_t st_ff;
	dsm_mon_t nxt_st;

	logic antiv;
	logic sync_en;
	logic lock_en;
	logic a_act;
	logic b_act;
	logic both_act;
	logic none_act;
	logic mismatch;
	logic start_ok;
	logic go;
	logic [NTMR-1:0] t_run;
	logic [NTMR-1:0] t_done;
	logic [NEV-1:0] ev;
	logic [NEV-1:0] irq_stat;
	logic [NEV-1:0] irq_mask;
	logic wr_ctrl;

	localparam int unsigned TLIM [NTMR] = '{SYNC_CYC_P, LOCK_CYC_P, CLEAR_CYC_P, ACT_CYC_P};

	// ****************************************************************
	// Input decoding.
	// ****************************************************************
	// Returns the activated level of a channel; a closed contact is active high.
	function automatic logic chan_active(input logic level, input logic open_contact);
		chan_active = open_contact ? !level : level;
	endfunction

	assign antiv = st_ff.ctrl[CTRL_ANTIVALENT];
	assign sync_en = st_ff.ctrl[CTRL_SYNC_EN];
	assign lock_en = st_ff.ctrl[CTRL_LOCK_EN];
	// In antivalent mode the first channel is an open contact, else both are closed ones.
	assign a_act = chan_active(normally_open_channel, antiv);
	assign b_act = chan_active(normally_closed_channel, 1'b0);
	assign both_act = a_act && b_act;
	assign none_act = !a_act && !b_act;
	assign mismatch = a_act ^ b_act;
	assign start_ok = st_ff.ctrl[CTRL_AUTO_START] || start_in;
	// Every condition of the energize transition must hold together.
	assign go = start_ok && both_act && !st_ff.lock && !(sync_en && st_ff.sync_fail);

	// ****************************************************************
	// Timers.
	// ****************************************************************
	// Sync runs while channels differ; lock runs while one dropped from both active.
	assign t_run[T_SYNC] = mismatch;
	assign t_run[T_LOCK] = lock_en && st_ff.dropped && mismatch && !st_ff.lock;
	assign t_run[T_CLEAR] = st_ff.lock && none_act;
	assign t_run[T_ACT] = (st_ff.state == ST_DELAY) && go;

	genvar gi;
	generate
		for (gi = 0; gi < NTMR; gi++) begin : g_tmr
			dsm_timer #(
				.W(TMR_W),
				.LIMIT(TLIM[gi])
			) u_tmr (
				.clock(clock),
				.rst(rst),
				.run(t_run[gi]),
				.done(t_done[gi])
			);
		end
	endgenerate

	// ****************************************************************
	// Control and register logic.
	// ****************************************************************
	assign wr_ctrl = reg_wr && (reg_addr == REG_CTRL);

	// One process holds the operating state machine, alerts, the control register and all register reads.
	always_comb begin
		nxt_st = st_ff;
		ev = '0;
		if (wr_ctrl) begin
			nxt_st.ctrl = reg_wdata;
		end
		// A mismatch outliving the sync window is an alert with sync_en or antivalent set, and blocks energizing only with sync_en set.
		if (t_done[T_SYNC] && (sync_en || antiv) && !st_ff.sync_fail) begin
			nxt_st.sync_fail = 1'b1;
			ev[EV_SYNC_ALERT] = 1'b1;
		end else if (none_act) begin
			nxt_st.sync_fail = 1'b0;
		end
		// Track a drop that started from both inputs active.
		if (both_act && !st_ff.dropped) begin
			nxt_st.from_both = 1'b1;
		end
		if (st_ff.from_both && mismatch) begin
			nxt_st.dropped = 1'b1;
		end
		if (none_act) begin
			nxt_st.from_both = 1'b0;
			nxt_st.dropped = 1'b0;
		end
		// Interlock: window expired, or the dropped input came back first.
		if (lock_en && !st_ff.lock && st_ff.dropped && (t_done[T_LOCK] || both_act)) begin
			nxt_st.lock = 1'b1;
			nxt_st.from_both = 1'b0;
			nxt_st.dropped = 1'b0;
			ev[EV_LOCK_ALERT] = 1'b1;
		end else if (t_done[T_CLEAR]) begin
			nxt_st.lock = 1'b0;
			ev[EV_LOCK_CLEAR] = 1'b1;
		end
		case (st_ff.state)
			ST_DEEN: begin
				nxt_st.out = 1'b0;
				if (go) begin
					nxt_st.state = ST_DELAY;
				end
			end
			ST_DELAY: begin
				if (!go) begin
					nxt_st.state = ST_DEEN;
				end else if (t_done[T_ACT]) begin
					nxt_st.state = ST_ENERG;
					nxt_st.out = 1'b1;
					ev[EV_ENERGIZE] = 1'b1;
				end
			end
			ST_ENERG: begin
				// Dropping in one cycle keeps well inside any response time.
				if (!both_act) begin
					nxt_st.state = ST_DEEN;
					nxt_st.out = 1'b0;
					ev[EV_DEENERGIZE] = 1'b1;
				end
			end
			default: begin
				nxt_st.state = ST_DEEN;
				nxt_st.out = 1'b0;
			end
		endcase
		// Read data stand only in the cycle after the strobe; unmapped reads zero.
		nxt_st.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				REG_CTRL: nxt_st.rdata = st_ff.ctrl;
				REG_STATUS: nxt_st.rdata = {st_ff.lock, st_ff.sync_fail, b_act, a_act,
					st_ff.out, 1'b0, st_ff.state};
				REG_IRQ_STAT: nxt_st.rdata = DW'(irq_stat);
				REG_IRQ_MASK: nxt_st.rdata = DW'(irq_mask);
				default: nxt_st.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_ff <= '{state: ST_DEEN, ctrl: CTRL_RST, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************************************
	// Interrupts and outputs.
	// ****************************************************************
	dsm_irq #(
		.N(NEV)
	) u_irq (
		.clock(clock),
		.rst(rst),
		.set(ev),
		.clr_wr(reg_wr && (reg_addr == REG_IRQ_STAT)),
		.clr_data(reg_wdata[NEV-1:0]),
		.mask_wr(reg_wr && (reg_addr == REG_IRQ_MASK)),
		.mask_data(reg_wdata[NEV-1:0]),
		.status(irq_stat),
		.mask(irq_mask),
		.irq(irq)
	);

	assign safety_out = st_ff.out;
	assign reg_rdata = st_ff.rdata;

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	sync_block_a: assert property (
		$rose(safety_out) |-> !($past(sync_en) && $past(st_ff.sync_fail)))
		else $error("Output energized after failed synchronization.");

	no_start_a: assert property (
		(st_ff.state == ST_DEEN && !start_ok) |=> !safety_out ##1 !safety_out)
		else $error("Output energized without start condition.");

	act_delay_a: assert property (
		(st_ff.state == ST_DELAY && go && t_done[T_ACT]) |=> safety_out && irq_stat[EV_ENERGIZE])
		else $error("Output not energized when activation delay elapsed.");

	resp_time_a: assert property (
		(safety_out && !both_act) |=> !safety_out && st_ff.state == ST_DEEN)
		else $error("Output not deenergized within response time.");

	lock_fast_a: assert property (
		(lock_en && st_ff.dropped && both_act && !st_ff.lock) |=> st_ff.lock && irq_stat[EV_LOCK_ALERT])
		else $error("Reactivation during drop window did not interlock.");

	antiv_on_a: assert property (
		(antiv && !normally_open_channel && normally_closed_channel) |-> both_act)
		else $error("Antivalent activated pattern not decoded.");

	antiv_off_a: assert property (
		(antiv && normally_open_channel && !normally_closed_channel && safety_out) |=> !safety_out)
		else $error("Antivalent deactivated pattern did not deenergize.");

	equal_alert_a: assert property (
		(antiv && t_done[T_SYNC] && !st_ff.sync_fail) |=> st_ff.sync_fail && irq_stat[EV_SYNC_ALERT])
		else $error("Equal levels beyond sync time raised no alert.");

	go_cond_a: assert property (
		$rose(safety_out) |-> $past(go) && $past(st_ff.state) == ST_DELAY)
		else $error("Energized without all transition conditions.");

	lock_hold_a: assert property (
		st_ff.lock |=> !$rose(safety_out))
		else $error("Energized while interlock present.");

	lock_clear_a: assert property (
		$fell(st_ff.lock) |-> $past(t_done[T_CLEAR]) && $past(none_act))
		else $error("Interlock cleared without one second of deactivation.");

	lock_window_a: assert property (
		(lock_en && st_ff.dropped && t_done[T_LOCK] && !st_ff.lock) |=> st_ff.lock && irq_stat[EV_LOCK_ALERT])
		else $error("Expired drop window did not interlock.");

	clear_event_a: assert property (
		$fell(st_ff.lock) |-> irq_stat[EV_LOCK_CLEAR])
		else $error("Interlock cleared without its event.");

	drop_event_a: assert property (
		$fell(safety_out) |-> irq_stat[EV_DEENERGIZE])
		else $error("Output deenergized without its event.");

endmodule

// File: core/dsm_pkg.sv
/*
 * Shared constants of the dual channel safety input monitor: register map,
 * control field positions, reset values, event bits and timing figures.
 * Assumes a 50 MHz system clock; all cycle counts are derived from that rate.
 */

package dsm_pkg;

	// ****************************************************************
	// Clock and timing figures.
	// ****************************************************************
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	// Window for the second channel to follow the first, in ms.
	localparam int unsigned SYNC_MS = 500;
	// Delay from start condition to energized output, in ms.
	localparam int unsigned ACT_MS = 50;
	// Longest allowed time from deactivation to deenergized output, in ms.
	localparam int unsigned RESP_MS = 20;
	// Both inputs must drop inside this window, in ms.
	localparam int unsigned LOCK_MS = 200;
	// Both inputs must stay dropped this long to leave interlock, in ms.
	localparam int unsigned CLEAR_MS = 1000;
	localparam int unsigned SYNC_CYC = SYNC_MS * CYC_PER_MS;
	localparam int unsigned ACT_CYC = ACT_MS * CYC_PER_MS;
	localparam int unsigned RESP_CYC = RESP_MS * CYC_PER_MS;
	localparam int unsigned LOCK_CYC = LOCK_MS * CYC_PER_MS;
	localparam int unsigned CLEAR_CYC = CLEAR_MS * CYC_PER_MS;
	localparam int unsigned TMR_W = 26;

	// ****************************************************************
	// Register map and fields.
	// ****************************************************************
	localparam int unsigned AW = 4;
	localparam int unsigned DW = 8;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_IRQ_STAT = 4'h8;
	localparam logic [3:0] REG_IRQ_MASK = 4'hC;
	localparam int unsigned CTRL_ANTIVALENT = 0;
	localparam int unsigned CTRL_SYNC_EN = 1;
	localparam int unsigned CTRL_LOCK_EN = 2;
	localparam int unsigned CTRL_AUTO_START = 3;
	localparam logic [7:0] CTRL_RST = 8'h07;
	localparam logic [7:0] MASK_RST = 8'h00;

	// Event bits of the interrupt status register.
	localparam int unsigned NEV = 5;
	localparam int unsigned EV_ENERGIZE = 0;
	localparam int unsigned EV_DEENERGIZE = 1;
	localparam int unsigned EV_SYNC_ALERT = 2;
	localparam int unsigned EV_LOCK_ALERT = 3;
	localparam int unsigned EV_LOCK_CLEAR = 4;

	// Timer slots.
	localparam int unsigned NTMR = 4;
	localparam int unsigned T_SYNC = 0;
	localparam int unsigned T_LOCK = 1;
	localparam int unsigned T_CLEAR = 2;
	localparam int unsigned T_ACT = 3;

	typedef enum logic [1:0] {
		ST_DEEN,
		ST_DELAY,
		ST_ENERG
	} dsm_state_t;

endpackage

// File: core/dsm_timer.sv
/*
 * Elapsed-time counter: counts while run is high, clears when it drops.
 * Assumes run is a synchronous level; done is high while run has lasted LIMIT cycles.
 */
`timescale 1ns/1ps

module dsm_timer #(
	parameter int unsigned W = 26,
	parameter int unsigned LIMIT = 1
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic run,
	output logic done
);
	import dsm_pkg::*;

	typedef struct packed {
		logic [W-1:0] cnt;
	} dsm_tmr_t;

	localparam logic [W-1:0] LIM_W = W'(LIMIT);

	dsm_tmr_t st_ff;
	dsm_tmr_t nxt_st;

	// The counter saturates at the limit so done holds as long as run does.
	always_comb begin
		nxt_st = st_ff;
		if (!run) begin
			nxt_st.cnt = '0;
		end else if (st_ff.cnt != LIM_W) begin
			nxt_st.cnt = st_ff.cnt + W'(1);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign done = run && (st_ff.cnt == LIM_W);

endmodule

// File: core/dsm_irq.sv
/*
 * Sticky event status with write-one-to-clear, a mask, and one level interrupt.
 * Assumes set pulses are synchronous; a set in the cycle of a clear wins.
 */
`timescale 1ns/1ps

module dsm_irq #(
	parameter int unsigned N = 5
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [N-1:0] set,
	input wire logic clr_wr,
	input wire logic [N-1:0] clr_data,
	input wire logic mask_wr,
	input wire logic [N-1:0] mask_data,
	output logic [N-1:0] status,
	output logic [N-1:0] mask,
	output logic irq
);
	import dsm_pkg::*;

	typedef struct packed {
		logic [N-1:0] stat;
		logic [N-1:0] mask;
		logic irq;
	} dsm_irq_t;

	dsm_irq_t st_ff;
	dsm_irq_t nxt_st;

	// Set is applied after clear so an event is never lost to a clear.
	always_comb begin
		nxt_st = st_ff;
		if (clr_wr) begin
			nxt_st.stat = st_ff.stat & ~clr_data;
		end
		nxt_st.stat = nxt_st.stat | set;
		if (mask_wr) begin
			nxt_st.mask = mask_data;
		end
		nxt_st.irq = |(nxt_st.stat & nxt_st.mask);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_ff <= '{stat: '0, mask: N'(MASK_RST), irq: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign status = st_ff.stat;
	assign mask = st_ff.mask;
	assign irq = st_ff.irq;

endmodule

// File: test/dsm_field_model.sv
/*
 * Field side of the safety input monitor: two contacts and a start pushbutton.
 * Assumes the bench commands activation per channel; the model turns it into contact levels.
 */
`timescale 1ns/1ps

module dsm_field_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic want_a,
	input wire logic want_b,
	input wire logic press,
	input wire logic antivalent,
	output logic normally_open_channel,
	output logic normally_closed_channel,
	output logic start_in
);

	// ****************************************************************
	// Contact levels.
	// ****************************************************************
	// The contacts are registered, so every change reaches the monitor one cycle late.
	// This mimics a real switch that never moves in the same instant as its command.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			normally_open_channel <= 1'b1;
			normally_closed_channel <= 1'b0;
			start_in <= 1'b0;
		end else begin
			// A normally open contact reads 0 when active in antivalent wiring.
			normally_open_channel <= antivalent ? ~want_a : want_a;
			normally_closed_channel <= want_b;
			start_in <= press;
		end
	end

endmodule

// File: test/dsm_monitor_tb.sv
/*
 * Self-checking bench of the safety input monitor, with the field model on its inputs.
 * Assumes the short timing parameters below and the plain register port of the monitor.
 */
`timescale 1ns/1ps

module dsm_monitor_tb;
	import dsm_pkg::*;

	// ****************************************************************
	// Short windows so that each one passes in a few dozen cycles.
	// ****************************************************************
	localparam int unsigned SYNC = 20;
	localparam int unsigned ACT = 4;
	localparam int unsigned RESP = 4;
	localparam int unsigned LOCK = 10;
	localparam int unsigned CLEAR = 30;

	logic clock;
	logic rst;
	logic want_a;
	logic want_b;
	logic press;
	logic antivalent;
	logic normally_open_channel;
	logic normally_closed_channel;
	logic start_in;
	logic [AW-1:0] reg_addr;
	logic [DW-1:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [DW-1:0] reg_rdata;
	logic safety_out;
	logic irq;
	int mismatches;
	int checks_done;

	dsm_field_model field (
		.clock(clock),
		.rst(rst),
		.want_a(want_a),
		.want_b(want_b),
		.press(press),
		.antivalent(antivalent),
		.normally_open_channel(normally_open_channel),
		.normally_closed_channel(normally_closed_channel),
		.start_in(start_in)
	);

	dsm_monitor #(
		.SYNC_CYC_P(SYNC),
		.ACT_CYC_P(ACT),
		.RESP_CYC_P(RESP),
		.LOCK_CYC_P(LOCK),
		.CLEAR_CYC_P(CLEAR)
	) dut (
		.clock(clock),
		.rst(rst),
		.normally_open_channel(normally_open_channel),
		.normally_closed_channel(normally_closed_channel),
		.start_in(start_in),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.safety_out(safety_out),
		.irq(irq)
	);

	// ****************************************************************
	// Clock, verdict and comparison helpers.
	// ****************************************************************
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	// Bus cycles change signals right after an edge and hold them for one whole cycle.
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample just past that edge.
	task automatic chk_rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp,
			input string what);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		check(what, reg_rdata & m, exp);
	endtask

	task automatic hold(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic set_in(input logic a, input logic b, input logic p);
		@(posedge clock);
		want_a <= a;
		want_b <= b;
		press <= p;
	endtask

	// Bounded wait for the output level; the model adds one cycle of lag.
	task automatic wait_out(input logic exp, input int limit);
		int n;
		n = 0;
		#1;
		while (safety_out !== exp && n < limit) begin
			@(posedge clock);
			#1;
			n++;
		end
		check("safety_out", {7'h00, safety_out}, {7'h00, exp});
	endtask

	// ****************************************************************
	// Scenarios.
	// ****************************************************************
	task automatic t_regs;
		chk_rd(REG_CTRL, 8'hFF, CTRL_RST, "ctrl");
		chk_rd(REG_IRQ_MASK, 8'hFF, MASK_RST, "mask");
		chk_rd(REG_IRQ_STAT, 8'hFF, 8'h00, "irq_stat");
		wr(4'h2, 8'hFF);
		chk_rd(4'h2, 8'hFF, 8'h00, "unmapped");
		wr(REG_STATUS, 8'hFF);
		chk_rd(REG_STATUS, 8'hFF, 8'h00, "status_idle");
		wr(REG_IRQ_MASK, 8'h1F);
		chk_rd(REG_IRQ_MASK, 8'hFF, 8'h1F, "mask");
	endtask

	// Inputs active but no start: the output must wait for the start button.
	task automatic t_start;
		set_in(1'b1, 1'b1, 1'b0);
		hold(30);
		check("out_no_start", {7'h00, safety_out}, 8'h00);
		chk_rd(REG_STATUS, 8'h30, 8'h30, "chan_active");
		set_in(1'b1, 1'b1, 1'b1);
		wait_out(1'b1, ACT + 5);
		chk_rd(REG_IRQ_STAT, 8'h01, 8'h01, "energize_event");
		check("irq_on", {7'h00, irq}, 8'h01);
		wr(REG_IRQ_STAT, 8'h1F);
		hold(2);
		check("irq_off", {7'h00, irq}, 8'h00);
	endtask

	// Both channels drop together: quick release, no interlock left behind.
	task automatic t_drop;
		set_in(1'b0, 1'b0, 1'b1);
		wait_out(1'b0, RESP + 2);
		chk_rd(REG_IRQ_STAT, 8'h02, 8'h02, "deenergize_event");
		chk_rd(REG_STATUS, 8'h83, 8'h00, "status_safe");
		wr(REG_IRQ_STAT, 8'h1F);
	endtask

	// Second channel far too late: alert raised, energizing refused until both reset.
	task automatic t_sync;
		set_in(1'b1, 1'b0, 1'b1);
		hold(SYNC + 5);
		chk_rd(REG_IRQ_STAT, 8'h04, 8'h04, "sync_alert");
		check("irq_sync", {7'h00, irq}, 8'h01);
		wr(REG_IRQ_MASK, 8'h00);
		hold(2);
		check("irq_masked", {7'h00, irq}, 8'h00);
		set_in(1'b1, 1'b1, 1'b1);
		hold(ACT + 10);
		check("out_sync_fail", {7'h00, safety_out}, 8'h00);
		set_in(1'b0, 1'b0, 1'b1);
		hold(5);
		set_in(1'b1, 1'b1, 1'b1);
		wait_out(1'b1, ACT + 5);
		wr(REG_IRQ_STAT, 8'h1F);
	endtask

	// One channel stays active past the window: interlock holds until a full clear time.
	task automatic t_lock;
		set_in(1'b1, 1'b0, 1'b1);
		wait_out(1'b0, RESP + 2);
		hold(LOCK + 5);
		chk_rd(REG_IRQ_STAT, 8'h08, 8'h08, "lock_alert");
		set_in(1'b0, 1'b0, 1'b1);
		hold(5);
		set_in(1'b1, 1'b1, 1'b1);
		hold(ACT + 10);
		check("out_locked", {7'h00, safety_out}, 8'h00);
		set_in(1'b0, 1'b0, 1'b1);
		hold(CLEAR + 5);
		chk_rd(REG_IRQ_STAT, 8'h10, 8'h10, "lock_clear");
		set_in(1'b1, 1'b1, 1'b1);
		wait_out(1'b1, ACT + 5);
		wr(REG_IRQ_STAT, 8'h1F);
	endtask

	// First channel returns before the second drops: alert long before the window ends.
	task automatic t_relock;
		set_in(1'b0, 1'b1, 1'b1);
		wait_out(1'b0, RESP + 2);
		set_in(1'b1, 1'b1, 1'b1);
		hold(4);
		chk_rd(REG_IRQ_STAT, 8'h08, 8'h08, "early_lock");
		set_in(1'b0, 1'b0, 1'b1);
		hold(CLEAR + 5);
		wr(REG_IRQ_STAT, 8'h1F);
	endtask

	// Plain active-high wiring with auto start: no start button needed.
	task automatic t_mode;
		set_in(1'b0, 1'b0, 1'b0);
		wr(REG_CTRL, 8'h0E);
		antivalent <= 1'b0;
		hold(3);
		set_in(1'b1, 1'b1, 1'b0);
		wait_out(1'b1, ACT + 5);
		chk_rd(REG_STATUS, 8'h0B, 8'h0A, "status_energized");
		set_in(1'b0, 1'b0, 1'b0);
		wait_out(1'b0, RESP + 2);
	endtask

	// Sync and interlock both off: a late second channel neither alerts nor blocks.
	task automatic t_noguard;
		wr(REG_CTRL, 8'h08);
		wr(REG_IRQ_STAT, 8'h1F);
		set_in(1'b1, 1'b1, 1'b0);
		wait_out(1'b1, ACT + 5);
		set_in(1'b1, 1'b0, 1'b0);
		wait_out(1'b0, RESP + 2);
		hold(SYNC + 5);
		chk_rd(REG_IRQ_STAT, 8'h0C, 8'h00, "no_alerts");
		set_in(1'b1, 1'b1, 1'b0);
		wait_out(1'b1, ACT + 5);
	endtask

	// ****************************************************************
	// Main sequence and watchdog.
	// ****************************************************************
	initial begin
		mismatches = 0;
		checks_done = 0;
		rst = 1'b1;
		want_a = 1'b0;
		want_b = 1'b0;
		press = 1'b0;
		antivalent = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		t_regs();
		t_start();
		t_drop();
		t_sync();
		t_lock();
		t_relock();
		t_mode();
		t_noguard();
		report_and_stop();
	end

	// The whole sequence needs well under a thousand cycles; a hang ends here.
	initial begin
		repeat (5000) @(posedge clock);
		mismatches++;
		report_and_stop();
	end

endmodule
